// file: ber_defs.vh
`ifndef BER_DEFS_VH
`define BER_DEFS_VH

// Register byte offsets
`define OFF_PATTERN_SET 8'h00
`define OFF_PATTERN_LENGTH 8'h04
`define OFF_POLY_TAP 8'h08
`define OFF_PATTERN_CONTROL 8'h0C
`define OFF_ERROR_INSERT 8'h10
`define OFF_STATUS 8'h14
`define OFF_ERROR_COUNT 8'h18
`define OFF_BIT_COUNT 8'h1C
`define OFF_PATTERN_RECEIVE 8'h20
`define OFF_INT_STATUS 8'h24
`define OFF_INT_MASK 8'h28

// Pattern control fields
`define CTL_MODE_REP 0
`define CTL_SYNC_EN 1
`define CTL_RESYNC 2
`define CTL_COUNT_LATCH 3
`define CTL_TX_LOAD 7

// Error insertion fields
`define INS_RATE_HI 2
`define INS_SINGLE 3

// Status fields
`define STAT_IN_SYNC 0
`define STAT_LEVEL_LO 1
`define STAT_LEVEL_HI 2
`define STAT_BUS_STYLE 3

// Interrupt event fields
`define EV_SYNC_GAIN 0
`define EV_SYNC_LOSS 1
`define EV_BIT_ERROR 2
`define EV_COUNT_LATCHED 3

// Reset values
`define RST_WORD 32'h00000000
`define RST_BYTE 8'h00

// Bits of error-free run before sync, added to the exponent
`define SYNC_BASE 7'd34

// Error insertion intervals, one error per this many bits
`define RATE_E1 24'd10
`define RATE_E2 24'd100
`define RATE_E3 24'd1000
`define RATE_E4 24'd10000
`define RATE_E5 24'd100000
`define RATE_E6 24'd1000000
`define RATE_E7 24'd10000000

`endif

// file: ber_tester.v
`timescale 1ns/1ps
`include "ber_defs.vh"
// How it works
// - Generator makes PRBS or repeating 1-32 bit pattern
// - Length and feedback tap both programmable
// - Host programs registers, then toggles transmit load
// - Load edge; MSB out after third tx edge
// - Receiver checks input, steered by sync/resync bits
// - PRBS receive accepts any stream fitting polynomial
// - Sync after 34 plus n clean bits
// - In sync: flag set, errors counted
// - Repetitive mode accepts same-length repeating pattern
// - Received pattern and level flags readable
// - 32-bit error and bit counters
// - Load count ends the integration interval
// - Invert bits: single or one in 10^k
// - Transmit and receive run on separate clocks
// - Works from static clock up to 52 MHz
// - All setup and results via host port
// - Bus style strap is only read back in status bit 3
module ber_tester
(
  // System
  input wire MCLK,
  input wire RST,
  // AHB-Lite slave
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // Transmit link
  input wire TX_CLK,
  input wire TX_LOAD,
  output reg TX_DATA,
  // Receive link
  input wire RX_CLK,
  input wire RX_DATA,
  // Control pins
  input wire COUNT_LATCH,
  input wire BUS_STYLE,
  // Interrupt
  output reg IRQ
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

// Pin synchronisers: stage 1 read only by stage 2
reg [5:0] pin_s1_q; // TX_CLK, TX_LOAD, RX_CLK, RX_DATA, COUNT_LATCH, BUS_STYLE
reg [5:0] pin_s2_q;
reg [2:0] pin_prev_q; // Previous TX_CLK, TX_LOAD, RX_CLK for edges
reg latch_prev_q;
// Software registers
reg [31:0] pset_q; // Pattern set
reg [4:0] plen_q; // Pattern length minus one
reg [4:0] ptap_q; // Feedback tap minus one
reg [7:0] ctl_q; // Pattern control
reg [3:0] ins_q; // Error insertion
reg [3:0] imask_q; // Interrupt mask
reg [3:0] ist_q; // Sticky interrupt status
// Bus data phase
reg wr_q; // Write pending in data phase
reg [7:0] waddr_q; // Address of that write
// Transmit side
reg load_pend_q; // Load seen, waiting for first tx edge
reg load_arm_q; // Second tx edge copies the pattern
reg tx_run_q; // Generator shifting
reg [31:0] tx_sr_q; // Generator shift register
reg single_q; // One-shot error request
reg [23:0] rate_cnt_q; // Bits since last inserted error
// Receive side
reg [31:0] rx_hist_q; // Last 32 received bits, newest at bit 0
reg [5:0] rx_fill_q; // Bits received since reset, saturating at 32
reg [6:0] clean_q; // Consecutive error-free bits
reg in_sync_q;
reg [31:0] err_run_q; // Running error count
reg [31:0] bit_run_q; // Running bit count
reg [31:0] err_hold_q; // Latched error count
reg [31:0] bit_hold_q; // Latched bit count
// Combinational
wire tx_edge;
wire rx_edge;
wire load_pin_rise;
wire latch_pin_rise;
wire rx_bit;
wire wr_ctl;
wire [7:0] ctl_new;
wire load_evt;
wire count_evt;
wire resync_evt;
wire single_wr;
wire tx_out;
wire [23:0] rate_lim;
wire rate_hit;
wire rx_expect;
wire rx_err;
wire [6:0] sync_tgt;
wire sync_gain;
wire sync_loss;
wire [31:0] err_inc;
wire [31:0] bit_inc;
wire [3:0] ev;
wire [3:0] ist_clr;
wire addr_ok;
reg [31:0] rd_d;

////////////////////////////////////////////////////////////////////////////////
// Functions

// Interval between inserted errors for a rate code
function [23:0] rate_limit;
  input [2:0] code;
  begin
    case (code)
      3'h1: rate_limit = `RATE_E1;
      3'h2: rate_limit = `RATE_E2;
      3'h3: rate_limit = `RATE_E3;
      3'h4: rate_limit = `RATE_E4;
      3'h5: rate_limit = `RATE_E5;
      3'h6: rate_limit = `RATE_E6;
      3'h7: rate_limit = `RATE_E7;
      default: rate_limit = 24'h000000;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin sampling and edge detection

// Both link clocks are sampled, so each must stay below a quarter of MCLK;
// 52 MHz against 250 MHz leaves margin, and a stopped clock just idles
always @(posedge MCLK)
begin
  if (RST)
  begin
    pin_s1_q <= 6'h00;
    pin_s2_q <= 6'h00;
    pin_prev_q <= 3'h0;
    latch_prev_q <= 1'b0;
  end
  else
  begin
    pin_s1_q <= {BUS_STYLE, COUNT_LATCH, RX_DATA, RX_CLK, TX_LOAD, TX_CLK};
    pin_s2_q <= pin_s1_q;
    pin_prev_q <= {pin_s2_q[2], pin_s2_q[1], pin_s2_q[0]};
    latch_prev_q <= pin_s2_q[4];
  end
end

// Each side has its own clock edge, fully separate
assign tx_edge = pin_s2_q[0] & ~pin_prev_q[0];
assign rx_edge = pin_s2_q[2] & ~pin_prev_q[2];
assign load_pin_rise = pin_s2_q[1] & ~pin_prev_q[1];
assign latch_pin_rise = pin_s2_q[4] & ~latch_prev_q;
// Data and clock share synchroniser depth, so data is the value at the edge
assign rx_bit = pin_s2_q[3];

////////////////////////////////////////////////////////////////////////////////
// Bus decode and control events

assign addr_ok = HSEL & HTRANS[1] & HREADY;
assign wr_ctl = wr_q & (waddr_q == `OFF_PATTERN_CONTROL);
assign ctl_new = wr_ctl ? HWDATA[7:0] : ctl_q;
// Load, latch and resync bits act on their rising edge; load pin ORed with bit 7
assign load_evt = load_pin_rise | (wr_ctl & ctl_new[`CTL_TX_LOAD] & ~ctl_q[`CTL_TX_LOAD]);
assign count_evt = latch_pin_rise | (wr_ctl & ctl_new[`CTL_COUNT_LATCH] & ~ctl_q[`CTL_COUNT_LATCH]);
assign resync_evt = wr_ctl & ctl_new[`CTL_RESYNC] & ~ctl_q[`CTL_RESYNC];
assign single_wr = wr_q & (waddr_q == `OFF_ERROR_INSERT) & HWDATA[`INS_SINGLE];
assign ist_clr = (wr_q & (waddr_q == `OFF_INT_STATUS)) ? HWDATA[3:0] : 4'h0;

////////////////////////////////////////////////////////////////////////////////
// Register file writes

// All configuration goes through the bus slave
always @(posedge MCLK)
begin
  if (RST)
  begin
    pset_q <= `RST_WORD;
    plen_q <= 5'h00;
    ptap_q <= 5'h00;
    ctl_q <= `RST_BYTE;
    ins_q <= 4'h0;
    imask_q <= 4'h0;
  end
  else if (wr_q)
  begin
    // Single error bit is a strobe, never stored
    if (waddr_q == `OFF_PATTERN_SET)
      pset_q <= HWDATA;
    else if (waddr_q == `OFF_PATTERN_LENGTH)
      plen_q <= HWDATA[4:0];
    else if (waddr_q == `OFF_POLY_TAP)
      ptap_q <= HWDATA[4:0];
    else if (waddr_q == `OFF_PATTERN_CONTROL)
      ctl_q <= HWDATA[7:0];
    else if (waddr_q == `OFF_ERROR_INSERT)
      ins_q <= {1'b0, HWDATA[`INS_RATE_HI:0]};
    else if (waddr_q == `OFF_INT_MASK)
      imask_q <= HWDATA[3:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave: zero wait states, always OKAY

// Read data is prepared in the address phase so it leaves a flip-flop
always @*
begin
  rd_d = 32'h00000000;
  if (HADDR == `OFF_PATTERN_SET)
    rd_d = pset_q;
  else if (HADDR == `OFF_PATTERN_LENGTH)
    rd_d = {27'h0000000, plen_q};
  else if (HADDR == `OFF_POLY_TAP)
    rd_d = {27'h0000000, ptap_q};
  else if (HADDR == `OFF_PATTERN_CONTROL)
    rd_d = {24'h000000, ctl_q};
  else if (HADDR == `OFF_ERROR_INSERT)
    rd_d = {28'h0000000, ins_q};
  else if (HADDR == `OFF_STATUS)
    rd_d = {28'h0000000, pin_s2_q[5], (&rx_hist_q), ~(|rx_hist_q), in_sync_q};
  else if (HADDR == `OFF_ERROR_COUNT)
    rd_d = err_hold_q;
  else if (HADDR == `OFF_BIT_COUNT)
    rd_d = bit_hold_q;
  else if (HADDR == `OFF_PATTERN_RECEIVE)
    rd_d = rx_hist_q;
  else if (HADDR == `OFF_INT_STATUS)
    rd_d = {28'h0000000, ist_q};
  else if (HADDR == `OFF_INT_MASK)
    rd_d = {28'h0000000, imask_q};
end

// Address phase capture and registered answer
always @(posedge MCLK)
begin
  if (RST)
  begin
    wr_q <= 1'b0;
    waddr_q <= 8'h00;
    HRDATA <= 32'h00000000;
    HREADYOUT <= 1'b1;
    HRESP <= 1'b0;
  end
  else
  begin
    wr_q <= addr_ok & HWRITE;
    waddr_q <= HADDR;
    HREADYOUT <= 1'b1;
    HRESP <= 1'b0;
    // Unmapped addresses read zero and ignore writes
    if (addr_ok & ~HWRITE)
      HRDATA <= rd_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Transmit pattern generator

assign rate_lim = rate_limit(ins_q[`INS_RATE_HI:0]);
assign rate_hit = (rate_lim != 24'h000000) && (rate_cnt_q == rate_lim - 24'h000001);
// Tap A is the length, tap B the programmed feedback point
assign tx_out = tx_sr_q[plen_q];

// Load edge, then arm on tx edge 1, copy on 2, MSB out on 3
always @(posedge MCLK)
begin
  if (RST)
  begin
    load_pend_q <= 1'b0;
    load_arm_q <= 1'b0;
    tx_run_q <= 1'b0;
    tx_sr_q <= `RST_WORD;
    TX_DATA <= 1'b0;
  end
  else
  begin
    if (load_evt)
      load_pend_q <= 1'b1;
    else if (tx_edge)
      load_pend_q <= 1'b0;
    if (tx_edge)
    begin
      load_arm_q <= load_pend_q;
      if (load_arm_q)
      begin
        // Copy pattern set; bit plen is the first bit sent
        tx_sr_q <= pset_q;
        tx_run_q <= 1'b1;
      end
      else if (tx_run_q)
      begin
        // PRBS feeds back length xor tap; repetitive just rotates
        if (ctl_q[`CTL_MODE_REP])
          tx_sr_q <= {tx_sr_q[30:0], tx_out};
        else
          tx_sr_q <= {tx_sr_q[30:0], tx_out ^ tx_sr_q[ptap_q]};
        // Inserted errors flip the line bit, not the generator state
        TX_DATA <= tx_out ^ single_q ^ rate_hit;
      end
    end
  end
end

// Error insertion timing on transmitted bits
always @(posedge MCLK)
begin
  if (RST)
  begin
    single_q <= 1'b0;
    rate_cnt_q <= 24'h000000;
  end
  else
  begin
    // A new request in the cycle it is used still survives
    if (single_wr)
      single_q <= 1'b1;
    else if (tx_edge & tx_run_q & ~load_arm_q)
      single_q <= 1'b0;
    if (tx_edge & tx_run_q & ~load_arm_q)
    begin
      if (rate_hit | (rate_lim == 24'h000000))
        rate_cnt_q <= 24'h000000;
      else
        rate_cnt_q <= rate_cnt_q + 24'h000001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Receive synchroniser and checker

// Prediction from received history: any stream fitting the polynomial,
// including all zeros, predicts itself; all ones fits repetitive mode only
assign rx_expect = ctl_q[`CTL_MODE_REP] ? rx_hist_q[plen_q] : (rx_hist_q[plen_q] ^ rx_hist_q[ptap_q]);
assign rx_err = (rx_fill_q > {1'b0, plen_q}) & (rx_bit != rx_expect);
// Exponent n is the length
assign sync_tgt = `SYNC_BASE + {2'b00, plen_q} + 7'd1;
assign sync_gain = rx_edge & ~in_sync_q & ctl_q[`CTL_SYNC_EN] & ~rx_err & (clean_q + 7'd1 >= sync_tgt);
assign sync_loss = in_sync_q & (resync_evt | ~ctl_q[`CTL_SYNC_EN]);

// History, fill level and sync state
always @(posedge MCLK)
begin
  if (RST)
  begin
    rx_hist_q <= `RST_WORD;
    rx_fill_q <= 6'h00;
    clean_q <= 7'h00;
    in_sync_q <= 1'b0;
  end
  else
  begin
    if (rx_edge)
    begin
      rx_hist_q <= {rx_hist_q[30:0], rx_bit};
      if (rx_fill_q != 6'h20)
        rx_fill_q <= rx_fill_q + 6'h01;
    end
    // Resync or disable drops sync and restarts the search
    if (sync_loss)
    begin
      in_sync_q <= 1'b0;
      clean_q <= 7'h00;
    end
    else if (sync_gain)
      in_sync_q <= 1'b1;
    else if (rx_edge & ~in_sync_q)
    begin
      // Count clean bits; an error restarts the run
      if (rx_err | ~ctl_q[`CTL_SYNC_EN])
        clean_q <= 7'h00;
      else if (clean_q != 7'h7F)
        clean_q <= clean_q + 7'h01;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Error and bit counters

// Only bits received while in sync are counted
assign err_inc = {31'h00000000, rx_edge & in_sync_q & rx_err};
assign bit_inc = {31'h00000000, rx_edge & in_sync_q};

// Latch running counts and restart from this cycle's bit
always @(posedge MCLK)
begin
  if (RST)
  begin
    err_run_q <= `RST_WORD;
    bit_run_q <= `RST_WORD;
    err_hold_q <= `RST_WORD;
    bit_hold_q <= `RST_WORD;
  end
  else if (count_evt)
  begin
    err_hold_q <= err_run_q;
    bit_hold_q <= bit_run_q;
    err_run_q <= err_inc;
    bit_run_q <= bit_inc;
  end
  else
  begin
    // Counters saturate rather than wrap, so a long interval reads full scale
    if (err_run_q != 32'hFFFFFFFF)
      err_run_q <= err_run_q + err_inc;
    if (bit_run_q != 32'hFFFFFFFF)
      bit_run_q <= bit_run_q + bit_inc;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts

assign ev = {count_evt, rx_edge & in_sync_q & rx_err, sync_loss, sync_gain};

// Sticky status; a set in the clearing cycle wins
always @(posedge MCLK)
begin
  if (RST)
  begin
    ist_q <= 4'h0;
    IRQ <= 1'b0;
  end
  else
  begin
    ist_q <= (ist_q & ~ist_clr) | ev;
    IRQ <= |(ist_q & imask_q);
  end
end

endmodule // ber_tester

// file: ber_tester_properties.sv
`timescale 1ns/1ps
`include "ber_defs.vh"
module ber_tester_properties
(
  // System
  input wire MCLK,
  input wire RST,
  // Host bus
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  // Link and pins
  input wire TX_CLK,
  input wire TX_LOAD,
  input wire TX_DATA,
  input wire RX_CLK,
  input wire RX_DATA,
  input wire COUNT_LATCH,
  input wire BUS_STYLE,
  input wire IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Address phase accepted by the slave
  wire taken = HSEL && HTRANS[1] && HREADY;
  wire rd_taken = taken && !HWRITE;
  reg mask_wr_q; // Data phase of a mask write
  reg [3:0] low_q; // Cycles the link clock has stayed low
  // Mark the data phase of a mask write
  always @(posedge MCLK)
  begin
    mask_wr_q <= !RST && taken && HWRITE && HADDR == `OFF_INT_MASK;
  end
  // Saturating count, so a parked link clock is told from its low half
  always @(posedge MCLK)
  begin
    if (RST || TX_CLK)
      low_q <= 4'h0;
    else if (low_q != 4'hF)
      low_q <= low_q + 4'h1;
  end
  ////////////////////////////////////////
  ready_always_a: assert property (HREADYOUT) else $error("ready dropped");
  resp_okay_a: assert property (!HRESP) else $error("error response");
  unmapped_zero_a: assert property (rd_taken && (HADDR > `OFF_INT_MASK || HADDR[1:0] != 2'h0)
    |=> HRDATA == 32'h00000000) else $error("unmapped read not zero");
  rdata_stands_a: assert property (!rd_taken |=> $stable(HRDATA)) else $error("read data moved");
  len_width_a: assert property (rd_taken && HADDR == `OFF_PATTERN_LENGTH
    |=> HRDATA[31:5] == 27'h0) else $error("length field too wide");
  strap_read_a: assert property (rd_taken && HADDR == `OFF_STATUS && BUS_STYLE == $past(BUS_STYLE, 4)
    |=> HRDATA[`STAT_BUS_STYLE] == $past(BUS_STYLE)) else $error("strap misread");
  tx_parked_a: assert property (low_q >= 4'h6 |-> $stable(TX_DATA)) else $error("data moved without clock");
  irq_masked_a: assert property (mask_wr_q && HWDATA == 32'h0 |-> ##[1:2] !IRQ) else $error("masked irq");
endmodule // ber_tester_properties

bind ber_tester ber_tester_properties chk (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_CLK(TX_CLK), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA),
  .RX_CLK(RX_CLK), .RX_DATA(RX_DATA), .COUNT_LATCH(COUNT_LATCH), .BUS_STYLE(BUS_STYLE), .IRQ(IRQ));

// file: link_loop.sv
`timescale 1ns/1ps
module link_loop
(
  // Device transmit side
  input wire tx_clk,
  input wire tx_data,
  // Bench request to corrupt one bit
  input wire flip,
  // Returned link
  output reg rx_clk,
  output reg rx_data
);
  initial rx_clk = 1'b0;
  initial rx_data = 1'b0;
  // Take each bit a full bit after launch, so it has settled
  always @(posedge tx_clk) rx_data <= tx_data ^ flip;
  // Returned clock lags a quarter bit: data stands a whole bit around its rise
  always @(tx_clk) rx_clk <= #8 tx_clk;
endmodule // link_loop

// file: tb_ber_tester.sv
`timescale 1ns/1ps
`include "ber_defs.vh"
module tb_ber_tester;
  // Design inputs
  reg MCLK = 1'b0;
  reg RST = 1'b1;
  reg HSEL = 1'b0;
  reg HWRITE = 1'b0;
  reg [7:0] HADDR = 8'h00;
  reg [1:0] HTRANS = 2'h0;
  reg [31:0] HWDATA = 32'h00000000;
  reg TX_CLK = 1'b0;
  reg TX_LOAD = 1'b0;
  reg COUNT_LATCH = 1'b0;
  reg BUS_STYLE = 1'b0;
  // Bench state
  reg flip = 1'b0;
  reg tx_run = 1'b0;
  reg rd_dp = 1'b0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, TX_DATA, RX_CLK, RX_DATA, IRQ;
  integer failures = 0, n_compared = 0, i, len, p;
  reg [65:0] rq[$]; // Notes: mask, expected over IRQ and read data
  reg tq[$]; // Notes: expected serial bits
  reg [31:0] pat;
  ////////////////////////////////////////
  always #2 MCLK = ~MCLK;
  // Link clock, phase unrelated to MCLK, parked low between bursts
  initial
  begin
    #0.7;
    forever #16 TX_CLK = tx_run ? ~TX_CLK : 1'b0;
  end
  ber_tester DUT (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .TX_CLK(TX_CLK), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA), .RX_CLK(RX_CLK), .RX_DATA(RX_DATA),
    .COUNT_LATCH(COUNT_LATCH), .BUS_STYLE(BUS_STYLE), .IRQ(IRQ));
  link_loop LINK (.tx_clk(TX_CLK), .tx_data(TX_DATA), .flip(flip), .rx_clk(RX_CLK), .rx_data(RX_DATA));
  ////////////////////////////////////////
  task finish_test;
  begin
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task check(input [32:0] got, input [32:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // One single AHB transfer; a read leaves its note first
  task xfer(input w, input [7:0] a, input [32:0] d, input [32:0] m);
  begin
    if (!w)
      rq.push_back({m, d & m});
    @(posedge MCLK);
    HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= a;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d[31:0]; rd_dp <= !w;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    rd_dp <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, {1'b0, d}, 33'h0);
  endtask
  task rd(input [7:0] a, input [32:0] e, input [32:0] m);
    xfer(1'b0, a, e, m);
  endtask
  // Run the link clock for k rises, then park it
  task run(input integer k);
  begin
    tx_run = 1'b1;
    repeat (k) @(posedge TX_CLK);
    @(negedge TX_CLK);
    tx_run = 1'b0;
    repeat (8) @(posedge MCLK);
  end
  endtask
  // Load by pin or by control bit 7 rising
  task load(input pin, input [31:0] ctl);
  begin
    wr(`OFF_PATTERN_CONTROL, ctl);
    if (pin)
    begin
      @(posedge MCLK) TX_LOAD <= 1'b1;
      repeat (4) @(posedge MCLK);
      TX_LOAD <= 1'b0;
    end
    else
      wr(`OFF_PATTERN_CONTROL, ctl | 32'h80);
    repeat (6) @(posedge MCLK);
  end
  endtask
  ////////////////////////////////////////
  // Read data is taken at the edge that ends the data phase
  always @(posedge MCLK)
  begin : rmon
    reg [65:0] n;
    if (rd_dp && HREADYOUT === 1'b1)
    begin
      n = rq.pop_front();
      check({IRQ, HRDATA} & n[65:33], n[32:0]);
    end
  end
  // Each serial bit is looked at after its launch has settled
  always @(posedge TX_CLK)
  begin
    if (tq.size() > 0)
    begin
      repeat (6) @(posedge MCLK);
      check({32'h0, TX_DATA}, {32'h0, tq.pop_front()});
    end
  end
  initial
  begin
    #200000;
    failures++;
    finish_test;
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h38532044));
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    for (i = 0; i <= 'h30; i = i + 4)
      rd(i[7:0], 33'h0, (i == `OFF_STATUS) ? 33'h1FFFFFFF9 : 33'h1FFFFFFFF);
    BUS_STYLE <= 1'b1;
    repeat (6) @(posedge MCLK);
    rd(`OFF_STATUS, 33'h8, 33'h8);
    // Repetitive pattern of random length, loaded by bit then by pin
    len = 5 + $urandom % 28;
    pat = $urandom;
    wr(`OFF_PATTERN_SET, pat);
    wr(`OFF_PATTERN_LENGTH, 32'(len - 1));
    wr(`OFF_POLY_TAP, 32'h0);
    wr(`OFF_ERROR_INSERT, 32'h0);
    wr(`OFF_INT_MASK, 32'h0);
    wr(`OFF_INT_STATUS, 32'hFFFFFFFF);
    rd(`OFF_PATTERN_LENGTH, {1'b0, 32'(len - 1)}, 33'h0FFFFFFFF);
    for (p = 0; p < 2; p++)
    begin
      load(p[0], 32'h1);
      run(2);
      for (i = 0; i < 2 * len; i++)
        tq.push_back(pat[len - 1 - (i % len)]);
      run(2 * len);
    end
    // Pseudorandom loop, x^7 + x^6 + 1: sync only after 34 + 7 clean bits
    wr(`OFF_PATTERN_SET, 32'h5A);
    wr(`OFF_PATTERN_LENGTH, 32'h6);
    wr(`OFF_POLY_TAP, 32'h5);
    wr(`OFF_INT_MASK, 32'h1);
    load(1'b0, 32'h2);
    run(30);
    rd(`OFF_STATUS, 33'h0, 33'h100000001);
    run(25);
    rd(`OFF_STATUS, 33'h100000001, 33'h100000001);
    wr(`OFF_INT_STATUS, 32'hFFFFFFFF);
    rd(`OFF_INT_STATUS, 33'h0, 33'h100000001);
    // Exact interval, link parked at both latches: pin, then control bit
    @(posedge MCLK) COUNT_LATCH <= 1'b1;
    repeat (4) @(posedge MCLK);
    COUNT_LATCH <= 1'b0;
    run(20);
    wr(`OFF_PATTERN_CONTROL, 32'hA);
    rd(`OFF_BIT_COUNT, 33'd20, 33'h0FFFFFFFF);
    rd(`OFF_ERROR_COUNT, 33'h0, 33'h0FFFFFFFF);
    // One corrupted bit is flagged and sync holds
    wr(`OFF_INT_MASK, 32'h4);
    flip = 1'b1;
    run(1);
    flip = 1'b0;
    run(50);
    rd(`OFF_INT_STATUS, 33'h100000004, 33'h100000004);
    rd(`OFF_STATUS, 33'h1, 33'h1);
    // Insertion rates read back; single strobe, then one in ten
    for (i = 1; i < 8; i++)
    begin
      wr(`OFF_ERROR_INSERT, i);
      rd(`OFF_ERROR_INSERT, i, 33'hF);
    end
    for (p = 0; p < 2; p++)
    begin
      wr(`OFF_INT_STATUS, 32'hFFFFFFFF);
      rd(`OFF_INT_STATUS, 33'h0, 33'h100000004);
      wr(`OFF_ERROR_INSERT, p ? 32'h1 : 32'h8);
      run(30);
      rd(`OFF_INT_STATUS, 33'h100000004, 33'h100000004);
    end
    wr(`OFF_ERROR_INSERT, 32'h0);
    // Resync drops sync until a fresh clean run; disable clears it
    wr(`OFF_PATTERN_CONTROL, 32'h6);
    rd(`OFF_STATUS, 33'h0, 33'h1);
    run(60);
    rd(`OFF_STATUS, 33'h1, 33'h1);
    wr(`OFF_PATTERN_CONTROL, 32'h0);
    rd(`OFF_STATUS, 33'h0, 33'h1);
    wr(`OFF_INT_MASK, 32'h0);
    rd(`OFF_INT_STATUS, 33'h0, 33'h100000000);
    // Repetitive all ones syncs and reads full; all zeros reads empty
    wr(`OFF_PATTERN_SET, 32'hFFFFFFFF);
    load(1'b0, 32'h3);
    run(56);
    rd(`OFF_STATUS, 33'h5, 33'h7);
    rd(`OFF_PATTERN_RECEIVE, 33'hFFFFFFFF, 33'h0FFFFFFFF);
    wr(`OFF_PATTERN_SET, 32'h0);
    load(1'b1, 32'h1);
    run(36);
    rd(`OFF_STATUS, 33'h2, 33'h7);
    rd(`OFF_PATTERN_RECEIVE, 33'h0, 33'h0FFFFFFFF);
    finish_test;
  end
endmodule // tb_ber_tester
